// *** design/sbp_pkg.sv ***
// sbp_pkg: shared types and constants for the static branch predictor.
// assumes a single core clock; the fetch/decode partner presents one branch per cycle.
package sbp_pkg;
   // ****************************************
   // sizes and encodings
   // ****************************************
   localparam int ADDR_W = 32;
   localparam int RAS_DEPTH = 16;
   localparam int RAS_PTR_W = 4;
   localparam logic [7:0] HINT_TAKEN = 8'h3E;
   localparam logic [7:0] HINT_NOT_TAKEN = 8'h2E;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
   localparam logic [RAS_PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [RAS_PTR_W-1:0] PTR_ZERO = 4'h0;

   typedef enum logic [2:0] {
      SBP_BR_NONE = 3'b000,
      SBP_BR_COND_REL = 3'b001,
      SBP_BR_UNCOND = 3'b010,
      SBP_BR_CALL = 3'b011,
      SBP_BR_RET = 3'b100,
      SBP_BR_INDIRECT = 3'b101,
      SBP_BR_PAUSE = 3'b110
   } sbp_kind_e;

   typedef enum logic [1:0] {
      SBP_SRC_STATIC = 2'b00,
      SBP_SRC_HINT = 2'b01,
      SBP_SRC_DYN = 2'b10,
      SBP_SRC_RAS = 2'b11
   } sbp_src_e;

   // one branch presented by decode
   typedef struct packed {
      logic valid;
      sbp_kind_e kind;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] next_pc;
      logic [7:0] prefix;
      logic prefix_valid;
      logic trace_build;
      logic btb_hit;
      logic btb_taken;
      logic [ADDR_W-1:0] btb_target;
      logic trace_ret_valid;
      logic [ADDR_W-1:0] trace_ret_target;
   } sbp_req_s;

   // prediction answer
   typedef struct packed {
      logic valid;
      logic taken;
      logic [ADDR_W-1:0] target;
      sbp_src_e source;
      logic alloc_ok;
      logic throttle;
      logic order_flush_mask;
   } sbp_resp_s;
endpackage

// *** design/sbp_predictor.sv ***
// sbp_predictor: direction and target prediction for one branch per cycle.
// assumes decode classifies branches and reports branch target buffer lookups.
//
// Summary of operation
// - with no branch_target_buffer history an active hint, else the static algorithm, decides direction.
// - unconditional branches and calls are predicted taken statically.
// - backward conditional branches are predicted taken statically.
// - forward conditional branches are predicted not taken statically.
// - indirect branches are predicted not taken statically.
// - prefix 3E is a taken hint and 2E a not-taken hint.
// - hints count only on relative conditional branches.
// - hints count only while a trace is being built.
// - an active hint beats the static rule when the buffer has no prediction.
// - hints are advice only and never change architectural results.
// - a sixteen-entry return stack supplies return targets.
// - call and return info kept with a resident trace is used beyond stack depth.
// - the spin-wait hint behaves as a no-operation.
// - the spin-wait hint throttles the loop and masks the ordering flush.
// - never-taken conditional branches get no buffer allocation.
// - an indirect branch with a buffer entry predicts its previous target.
`timescale 1ns/1ps
module sbp_predictor (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // request from decode
   input sbp_pkg::sbp_req_s req_in,
   // actual outcome from retire, for allocation decisions
   input wire logic resolved_taken_in,
   // prediction
   output sbp_pkg::sbp_resp_s resp_out
);
   import sbp_pkg::*;

   // ****************************************
   // combinational decision
   // ****************************************
   logic [ADDR_W-1:0] ras_mem_q [RAS_DEPTH];
   logic [RAS_PTR_W-1:0] ras_top_q;
   logic [RAS_PTR_W:0] ras_cnt_q;
   sbp_resp_s resp_d, resp_q;
   logic is_cond, hint_ok, hint_t, hint_nt, backward;

   assign is_cond = req_in.kind == SBP_BR_COND_REL;
   // hints gated by branch type and trace-build phase; ignoring them is always safe
   assign hint_ok = req_in.prefix_valid && is_cond && req_in.trace_build;
   assign hint_t = hint_ok && req_in.prefix == HINT_TAKEN;
   assign hint_nt = hint_ok && req_in.prefix == HINT_NOT_TAKEN;
   assign backward = req_in.target < req_in.pc;

   // priority: return stack, buffer, hint, static
   always_comb begin
      resp_d = '0;
      resp_d.valid = req_in.valid && req_in.kind != SBP_BR_NONE;
      resp_d.target = req_in.next_pc;
      resp_d.source = SBP_SRC_STATIC;
      case (req_in.kind)
         SBP_BR_PAUSE: begin
            resp_d.taken = 1'b0;
            resp_d.throttle = req_in.valid;
            resp_d.order_flush_mask = req_in.valid;
         end
         SBP_BR_RET: begin
            resp_d.taken = 1'b1;
            resp_d.source = SBP_SRC_RAS;
            if (req_in.trace_ret_valid) begin
               resp_d.target = req_in.trace_ret_target;
            end else if (ras_cnt_q != '0) begin
               resp_d.target = ras_mem_q[ras_top_q];
            end
         end
         SBP_BR_UNCOND, SBP_BR_CALL: begin
            resp_d.taken = 1'b1;
            resp_d.target = req_in.target;
         end
         SBP_BR_INDIRECT: begin
            if (req_in.btb_hit) begin
               resp_d.taken = 1'b1;
               resp_d.target = req_in.btb_target;
               resp_d.source = SBP_SRC_DYN;
            end else begin
               resp_d.taken = 1'b0;
            end
         end
         SBP_BR_COND_REL: begin
            if (req_in.btb_hit) begin
               resp_d.taken = req_in.btb_taken;
               resp_d.source = SBP_SRC_DYN;
            end else if (hint_t || hint_nt) begin
               resp_d.taken = hint_t;
               resp_d.source = SBP_SRC_HINT;
            end else begin
               resp_d.taken = backward;
            end
            if (resp_d.taken) begin
               resp_d.target = req_in.target;
            end
         end
         default: resp_d.taken = 1'b0;
      endcase
      // conditional branches only earn a buffer entry once taken
      resp_d.alloc_ok = resp_d.valid && !(is_cond && !resolved_taken_in);
   end

   // ****************************************
   // registered answer
   // ****************************************
   // outputs registered to keep decode timing paths short
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         resp_q <= '0;
      end else begin
         resp_q <= resp_d;
      end
   end
   assign resp_out = resp_q;

   // ****************************************
   // return address stack
   // ****************************************
   logic do_push, do_pop;
   assign do_push = req_in.valid && req_in.kind == SBP_BR_CALL;
   assign do_pop = req_in.valid && req_in.kind == SBP_BR_RET && ras_cnt_q != '0;

   // pointer wraps, so deep call chains lose the oldest entry rather than fault
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ras_top_q <= PTR_ZERO;
         ras_cnt_q <= '0;
      end else if (do_push) begin
         ras_top_q <= ras_top_q + PTR_ONE;
         if (ras_cnt_q != (RAS_PTR_W+1)'(RAS_DEPTH)) begin
            ras_cnt_q <= ras_cnt_q + 1'b1;
         end
      end else if (do_pop) begin
         ras_top_q <= ras_top_q - PTR_ONE;
         ras_cnt_q <= ras_cnt_q - 1'b1;
      end
   end

   // one storage slot per entry
   for (genvar i = 0; i < RAS_DEPTH; i++) begin : g_ras
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            ras_mem_q[i] <= ADDR_ZERO;
         end else if (do_push && (ras_top_q + PTR_ONE) == RAS_PTR_W'(i)) begin
            ras_mem_q[i] <= req_in.next_pc;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_uncond;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && (req_in.kind == SBP_BR_CALL || req_in.kind == SBP_BR_UNCOND)
         |=> resp_out.taken && resp_out.target == $past(req_in.target);
   endproperty
   a_uncond: assert property (p_uncond) else $error("unconditional not taken");

   property p_back;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && is_cond && !req_in.btb_hit && !hint_ok && backward |=> resp_out.taken;
   endproperty
   a_back: assert property (p_back) else $error("backward not taken");

   property p_fwd;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && is_cond && !req_in.btb_hit && !hint_ok && !backward
         |=> !resp_out.taken && resp_out.target == $past(req_in.next_pc);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward taken");

   property p_ind;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.kind == SBP_BR_INDIRECT && !req_in.btb_hit |=> !resp_out.taken;
   endproperty
   a_ind: assert property (p_ind) else $error("indirect static taken");

   property p_hint;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && is_cond && !req_in.btb_hit && req_in.trace_build && req_in.prefix_valid
         && req_in.prefix == HINT_NOT_TAKEN |=> !resp_out.taken && resp_out.source == SBP_SRC_HINT;
   endproperty
   a_hint: assert property (p_hint) else $error("not-taken hint ignored");

   property p_nobuild;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && !req_in.trace_build |=> resp_out.source != SBP_SRC_HINT;
   endproperty
   a_nobuild: assert property (p_nobuild) else $error("hint used outside build");

   property p_ras;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.kind == SBP_BR_CALL ##1
         req_in.valid && req_in.kind == SBP_BR_RET && !req_in.trace_ret_valid
         |=> resp_out.target == $past(req_in.next_pc, 2);
   endproperty
   a_ras: assert property (p_ras) else $error("return target wrong");

   property p_pause;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.kind == SBP_BR_PAUSE |=> resp_out.throttle && !resp_out.taken;
   endproperty
   a_pause: assert property (p_pause) else $error("pause not a throttled nop");

   property p_alloc;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && is_cond && !resolved_taken_in |=> !resp_out.alloc_ok;
   endproperty
   a_alloc: assert property (p_alloc) else $error("never-taken branch allocated");

   // buffer, hint and trace paths that the static checks above leave alone
   property p_ind_dyn;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.kind == SBP_BR_INDIRECT && req_in.btb_hit
         |=> resp_out.taken && resp_out.target == $past(req_in.btb_target);
   endproperty
   a_ind_dyn: assert property (p_ind_dyn) else $error("indirect ignored buffer target");

   property p_hint_tk;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && is_cond && !req_in.btb_hit && req_in.trace_build && req_in.prefix_valid
         && req_in.prefix == HINT_TAKEN
         |=> resp_out.taken && resp_out.target == $past(req_in.target);
   endproperty
   a_hint_tk: assert property (p_hint_tk) else $error("taken hint ignored");

   property p_trace_ret;
      @(posedge clk_in) disable iff (rst_in)
      req_in.valid && req_in.kind == SBP_BR_RET && req_in.trace_ret_valid
         |=> resp_out.taken && resp_out.target == $past(req_in.trace_ret_target);
   endproperty
   a_trace_ret: assert property (p_trace_ret) else $error("trace return target unused");
endmodule

// *** sim/sbp_fetch_model.sv ***
// sbp_fetch_model: stands in for fetch, decode and trace build.
// assumes the bench calls issue once per cycle, just after a rising edge.
`timescale 1ns/1ps
module sbp_fetch_model (
   // request toward the predictor
   output sbp_pkg::sbp_req_s req_out,
   output logic resolved_taken_out
);
   import sbp_pkg::*;
   // ****************************************
   // request drive
   // ****************************************
   initial begin
      req_out = '0;
      resolved_taken_out = 1'b0;
   end
   // a request stands until replaced, so callers must issue idles too
   task automatic issue(input sbp_req_s r, input logic rs);
      req_out <= r;
      resolved_taken_out <= rs;
   endtask
endmodule

// *** sim/sbp_predictor_tb.sv ***
// sbp_predictor_tb: reference model with a queue-based return stack.
// assumes the answer lands exactly one edge after the request.
`timescale 1ns/1ps
module sbp_predictor_tb;
   import sbp_pkg::*;
   typedef struct {bit v; bit tk; bit thr; bit al; logic [31:0] tg; int src; int c;} sbp_exp_s;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   sbp_req_s req;
   logic res;
   sbp_resp_s resp;
   sbp_exp_s q[$];
   sbp_exp_s e;
   logic [31:0] ras[$];
   logic [31:0] seed = 32'hf439;
   int cyc = 0;
   int error_cnt = 0;
   int checks = 0;
   always #4 clk_in = ~clk_in;
   sbp_fetch_model sbp_fetch_model_i (.req_out(req), .resolved_taken_out(res));
   sbp_predictor sbp_predictor_i (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
      .resolved_taken_in(res), .resp_out(resp));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      int n;
      n = 0;
      // answers still queued get a few cycles; a stuck queue counts as a mismatch
      while (q.size() > 0 && n < 8) begin
         @(posedge clk_in);
         n++;
      end
      if (q.size() > 0) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, q.size(), 0);
      end
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one request per cycle; the model decides the answer up front
   task automatic go(input int k, input logic [31:0] pc, tg, input logic [7:0] pf,
                     input bit pv, tb, hit, btk, trv, rs);
      sbp_req_s r;
      bit cond;
      bit hv;
      sbp_exp_s x;
      @(posedge clk_in);
      r = '{valid: k != 0, kind: sbp_kind_e'(k), pc: pc, target: tg, next_pc: pc + 32'h0000_0004,
            prefix: pf, prefix_valid: pv, trace_build: tb, btb_hit: hit, btb_taken: btk,
            btb_target: tg ^ 32'h0000_0100, trace_ret_valid: trv, trace_ret_target: tg};
      cond = (k == 1);
      hv = cond && pv && tb && !hit && (pf == HINT_TAKEN || pf == HINT_NOT_TAKEN);
      x = '{v: r.valid, tk: 0, thr: k == 6, al: r.valid && !(cond && !rs), tg: r.next_pc,
            src: 0, c: cyc};
      case (k)
         1: begin
            x.tk = hit ? btk : hv ? pf == HINT_TAKEN : tg < pc;
            x.src = hit ? 2 : hv ? 1 : 0;
         end
         2, 3: x.tk = 1;
         5: begin
            x.tk = hit;
            x.src = hit ? 2 : 0;
         end
         4: begin
            x.tk = 1;
            x.src = 3;
            // every return pops a non-empty stack, even when the trace supplies the target
            if (ras.size() > 0) x.tg = ras.pop_back();
            if (trv) x.tg = tg;
         end
         6: x.src = -1;
         default: x.src = -1;
      endcase
      if (x.tk && k != 4) x.tg = (hit && k == 5) ? r.btb_target : tg;
      if (k == 3) begin
         if (ras.size() == 16) void'(ras.pop_front());
         ras.push_back(r.next_pc);
      end
      sbp_fetch_model_i.issue(r, rs);
      q.push_back(x);
   endtask
   // ****************************************
   // answer checking
   // ****************************************
   always @(negedge clk_in) begin
      cyc++;
      if (q.size() > 0 && q[0].c == cyc - 2) begin
         e = q.pop_front();
         cmp_bit(resp.valid, e.v);
         if (e.v) begin
            cmp_bit(resp.taken, e.tk);
            cmp_word(resp.target, e.tg);
            cmp_bit(resp.throttle, e.thr);
            cmp_bit(resp.order_flush_mask, e.thr);
            cmp_bit(resp.alloc_ok, e.al);
            if (e.src >= 0) cmp_word({30'h0000_0000, resp.source}, e.src);
         end
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      cmp_bit(resp.valid, 1'b0);
      // every kind, both directions, both hint codes
      for (int k = 0; k < 7; k++)
         for (int h = 0; h < 4; h++)
            go(k, 32'h0000_1000, h[0] ? 32'h0000_0800 : 32'h0000_2000,
               h[1] ? HINT_TAKEN : HINT_NOT_TAKEN, 1, 1, 0, 0, 0, h[0]);
      // random back-to-back traffic, returns from the stack or the trace at random
      for (int i = 0; i < 600; i++) begin
         // step eight times so neighbouring kinds are not tied by the shift
         repeat (8) seed = lfsr(seed);
         go(seed[2:0] == 3'h7 ? 1 : seed[2:0], seed, lfsr(seed),
            seed[5:4] == 2'h0 ? HINT_TAKEN : seed[5:4] == 2'h1 ? HINT_NOT_TAKEN : seed[15:8],
            seed[6], seed[7], seed[3] && (seed[2:0] == 3'h1 || seed[2:0] == 3'h5),
            seed[16], seed[18], seed[17]);
      end
      // overflow by one, then drain past empty
      for (int i = 0; i < 17; i++)
         go(3, 32'h0000_4000 + i * 16, 32'h0000_8000, 0, 0, 0, 0, 0, 0, 1);
      for (int i = 0; i < 18; i++) go(4, 32'h0000_9000, 32'h0000_0000, 0, 0, 0, 0, 0, 0, 1);
      go(4, 32'h0000_9000, 32'h0000_5550, 0, 0, 0, 0, 0, 1, 1);
      // reset in mid-run empties the stack
      repeat (2) go(3, 32'h0000_6000, 32'h0000_7000, 0, 0, 0, 0, 0, 0, 1);
      repeat (3) go(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      @(posedge clk_in);
      rst_in <= 1'b1;
      ras.delete();
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      go(4, 32'h0000_9100, 32'h0000_0000, 0, 0, 0, 0, 0, 0, 1);
      repeat (3) go(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      end_sim;
   end
endmodule
